/* core/pcsu_chip_select.v */
// Chip-select decoder with ten windows, wait-state counter and ready override
`timescale 1ns/10ps
`include "pcsu_consts.vh"
module pcsu_chip_select
(
	input  wire        mclk,          // Bus clock
	input  wire        reset,         // Synchronous reset
	input  wire        clkEn,         // Freezes all state when low
	input  wire        cycleStart,    // Address state pulse of a bus cycle
	input  wire        cycleEnd,      // Last state pulse of a bus cycle
	input  wire [19:0] busAddr,       // Cycle address
	input  wire [2:0]  cycleStatus,   // Cycle type code
	input  wire        refreshCycle,  // Cycle started by refresh unit
	input  wire        pcbHit,        // Cycle hits peripheral register block
	input  wire        busReady,      // External ready pin
	input  wire        regWrite,      // Register write strobe
	input  wire        regRead,       // Register read strobe
	input  wire [4:0]  regIndex,      // Register index
	input  wire [15:0] regWdata,      // Register write data
	output reg  [15:0] regRdata_ff,   // Register read data
	output reg  [9:0]  selectN_ff,    // Active-low chip selects
	output reg         waitReq_ff,    // High while cycle must stretch
	output reg         busyClaim_ff   // High while a select is claimed
);
	// Per-select configuration
	reg  [9:0]  startBound_ff [0:9];  // Start window field
	reg  [3:0]  minWait_ff    [0:9];  // Minimum wait count
	reg  [9:0]  endBound_ff   [0:9];  // End window field
	reg  [9:0]  enable_ff;            // Select enable bits
	reg  [9:0]  skipEnd_ff;           // Skip end-check bits
	reg  [9:0]  memSpace_ff;          // Memory (1) or I/O (0) space
	reg  [9:0]  rdyEn_ff;             // Ready-enable bits
	// Ready pin synchroniser
	reg         rdySync1_ff;          // First stage
	reg         rdySync2_ff;          // Second stage
	reg         rdySync3_ff;          // Third stage
	reg         readyOk_ff;           // Filtered ready level
	// Wait state tracking
	reg  [3:0]  waitCount_ff;         // Remaining minimum waits
	reg         needRdy_ff;           // Claimed select honours ready
	reg  [3:0]  nxt_waitCount;        // Next wait count
	reg         nxt_needRdy;          // Next ready usage
	wire [9:0]  hitVec;               // Per-select match
	wire        memCycle;             // Cycle classed as memory
	wire        ioCycle;              // Cycle classed as I/O
	integer     k;                    // Loop index

	// Classify cycle; refresh counts as memory, INTA and HALT as neither
	assign memCycle = refreshCycle | (cycleStatus == `PCSU_ST_MEMRD)
		| (cycleStatus == `PCSU_ST_MEMWR) | (cycleStatus == `PCSU_ST_FETCH);
	assign ioCycle = ~refreshCycle & ((cycleStatus == `PCSU_ST_IORD)
		| (cycleStatus == `PCSU_ST_IOWR));

	// Picks the compared address bits for the space
	function [9:0] pickBits;
		input        isMem;
		input [19:0] addr;
		begin
			pickBits = isMem ? addr[19:10] : addr[15:6];
		end
	endfunction

	// Register write decode, start at even index, end at odd
	function isWrite;
		input       wr;
		input [4:0] idx;
		input [4:0] want;
		begin
			isWrite = wr & (idx == want);
		end
	endfunction

	// One duplicated decode and register set per select
	genvar g;
	generate
		for (g = 0; g < `PCSU_NUM_SEL; g = g + 1)
		begin : gSel
			wire [9:0] cmpAddr;  // Address bits for this select
			assign cmpAddr = pickBits(memSpace_ff[g], busAddr);
			// Match: enable, type, start, end, not control block
			assign hitVec[g] = enable_ff[g]
				& (memSpace_ff[g] ? memCycle : ioCycle)
				& (cmpAddr >= startBound_ff[g])
				& (skipEnd_ff[g] | (cmpAddr < endBound_ff[g]))
				& ~pcbHit;

			// Start and end register storage, reserved bits dropped
			always @(posedge mclk)
			begin
				if (reset)
				begin
					startBound_ff[g] <= `PCSU_RST_BOUND;
					minWait_ff[g]    <= `PCSU_RST_WAIT;
					endBound_ff[g]   <= `PCSU_RST_BOUND;
					enable_ff[g]     <= (g == `PCSU_BOOT_SEL);
					skipEnd_ff[g]    <= (g == `PCSU_BOOT_SEL);
					memSpace_ff[g]   <= 1'b1;
					rdyEn_ff[g]      <= 1'b1;
				end
				else if (clkEn)
				begin
					if (isWrite(regWrite, regIndex, 2 * g))
					begin
						// Start register
						startBound_ff[g] <= regWdata[`PCSU_BOUND_MSB:`PCSU_BOUND_LSB];
						minWait_ff[g]    <= regWdata[`PCSU_WAIT_MSB:`PCSU_WAIT_LSB];
					end
					else if (isWrite(regWrite, regIndex, 2 * g + 1))
					begin
						// End register
						endBound_ff[g] <= regWdata[`PCSU_BOUND_MSB:`PCSU_BOUND_LSB];
						enable_ff[g]   <= regWdata[`PCSU_ENABLE_BIT];
						skipEnd_ff[g]  <= regWdata[`PCSU_SKIPEND_BIT];
						memSpace_ff[g] <= regWdata[`PCSU_MEMSPACE_BIT];
						rdyEn_ff[g]    <= regWdata[`PCSU_RDYEN_BIT];
					end
				end
			end
		end
	endgenerate

	// Ready pin: three flops, change accepted when stages 2 and 3 agree
	always @(posedge mclk)
	begin
		if (reset)
		begin
			rdySync1_ff <= 1'b0;
			rdySync2_ff <= 1'b0;
			rdySync3_ff <= 1'b0;
			readyOk_ff  <= 1'b0;
		end
		else if (clkEn)
		begin
			rdySync1_ff <= busReady;
			rdySync2_ff <= rdySync1_ff;
			rdySync3_ff <= rdySync2_ff;
			if (rdySync2_ff == rdySync3_ff)
				readyOk_ff <= rdySync3_ff;
		end
	end

	// Claimed select's largest wait count and ready usage
	always @*
	begin
		nxt_waitCount = 4'h0;
		nxt_needRdy   = 1'b0;
		for (k = 0; k < `PCSU_NUM_SEL; k = k + 1)
		begin
			if (hitVec[k])
			begin
				if (minWait_ff[k] > nxt_waitCount)
					nxt_waitCount = minWait_ff[k];
				nxt_needRdy = nxt_needRdy | rdyEn_ff[k];
			end
		end
	end

	// Select outputs and wait generator over one bus cycle
	always @(posedge mclk)
	begin
		if (reset)
		begin
			selectN_ff   <= 10'h3ff;
			waitReq_ff   <= 1'b0;
			busyClaim_ff <= 1'b0;
			waitCount_ff <= 4'h0;
			needRdy_ff   <= 1'b0;
		end
		else if (clkEn)
		begin
			if (cycleEnd)
			begin
				// Drop all selects at cycle end
				selectN_ff   <= 10'h3ff;
				waitReq_ff   <= 1'b0;
				busyClaim_ff <= 1'b0;
				waitCount_ff <= 4'h0;
				needRdy_ff   <= 1'b0;
			end
			else if (cycleStart)
			begin
				// Assert with the address state
				selectN_ff   <= ~hitVec;
				busyClaim_ff <= |hitVec;
				waitCount_ff <= nxt_waitCount;
				needRdy_ff   <= nxt_needRdy;
				waitReq_ff   <= (nxt_waitCount != 4'h0) | (nxt_needRdy & ~readyOk_ff);
			end
			else if (busyClaim_ff)
			begin
				// Count minimum waits, then follow ready
				if (waitCount_ff != 4'h0)
				begin
					waitCount_ff <= waitCount_ff - 4'h1;
					waitReq_ff   <= (waitCount_ff != 4'h1) | (needRdy_ff & ~readyOk_ff);
				end
				else
					waitReq_ff <= needRdy_ff & ~readyOk_ff;
			end
		end
	end

	// Register read back; status shows selects currently driven
	always @(posedge mclk)
	begin
		if (reset)
			regRdata_ff <= 16'h0000;
		else if (clkEn && regRead)
		begin
			regRdata_ff <= 16'h0000;
			if (regIndex == `PCSU_IDX_STATUS)
				regRdata_ff <= {6'h00, ~selectN_ff};
			else if (regIndex < 5'h14)
			begin
				if (regIndex[0] == 1'b0)
					regRdata_ff <= {startBound_ff[regIndex[4:1]], 2'h0,
						minWait_ff[regIndex[4:1]]};
				else
					regRdata_ff <= {endBound_ff[regIndex[4:1]],
						enable_ff[regIndex[4:1]], 1'b0, skipEnd_ff[regIndex[4:1]],
						memSpace_ff[regIndex[4:1]], 1'b0, rdyEn_ff[regIndex[4:1]]};
			end
		end
	end
endmodule

/* core/pcsu_consts.vh */
// Constants of the programmable chip-select unit
// Overview of operation
// - Ten selects, each with its own decode copy
// - Select asserts in the address bus state
// - Decode both processor and refresh cycles
// - Memory window 1 Kbyte, I/O window 64 bytes
// - Enabled, type match, above start, below stop
// - Never select peripheral register block accesses
// - Read, write, fetch memory; I/O read/write I/O
// - Interrupt acknowledge and halt never select
// - After reset only boot select is active
// - Start field versus A19:10 or A15:6, inclusive
// - Start field resets to all ones
// - Wait field sets minimum waits, resets fifteen
// - Bus ready extends cycle after minimum waits
// - Each select owns start and end registers
// - Stop field compared strictly less than
// - Skip-end bit extends window to space top
// - Space bit picks memory or I/O decode
// - Ready-enable bit makes cycle wait for ready
`ifndef PCSU_CONSTS_VH
`define PCSU_CONSTS_VH
`define PCSU_NUM_SEL        10
`define PCSU_LOW_SEL        8
`define PCSU_BOOT_SEL       9
`define PCSU_IDX_STATUS     5'h14
`define PCSU_BOUND_MSB      15
`define PCSU_BOUND_LSB      6
`define PCSU_WAIT_MSB       3
`define PCSU_WAIT_LSB       0
`define PCSU_ENABLE_BIT     5
`define PCSU_SKIPEND_BIT    3
`define PCSU_MEMSPACE_BIT   2
`define PCSU_RDYEN_BIT      0
`define PCSU_RST_BOUND      10'h3ff
`define PCSU_RST_WAIT       4'hf
`define PCSU_ST_MEMRD       3'h0
`define PCSU_ST_MEMWR       3'h1
`define PCSU_ST_FETCH       3'h2
`define PCSU_ST_IORD        3'h3
`define PCSU_ST_IOWR        3'h4
`define PCSU_ST_INTA        3'h5
`define PCSU_ST_HALT        3'h6
`define PCSU_ST_IDLE        3'h7
`endif

/* testbench/pcsu_checker.sv */
// Port assertions for the chip-select decoder
`timescale 1ns/10ps
module pcsu_checker
(
	input wire mclk, reset, clkEn, cycleStart, cycleEnd, refreshCycle, pcbHit, busReady,
	input wire regWrite, regRead, waitReq_ff, busyClaim_ff,
	input wire [19:0] busAddr,
	input wire [2:0] cycleStatus,
	input wire [4:0] regIndex,
	input wire [15:0] regWdata, regRdata_ff,
	input wire [9:0] selectN_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Address state and last state of a cycle
	sequence cStart; clkEn && cycleStart && !cycleEnd; endsequence
	sequence cEnd; clkEn && cycleEnd; endsequence
	end_release_a: assert property (cEnd |=> selectN_ff == 10'h3ff)
		else $error("select held past cycle end");
	no_inta_halt_a: assert property (cStart ##0 (cycleStatus == 3'h5 || cycleStatus == 3'h6)
		|=> selectN_ff == 10'h3ff) else $error("select on inta or halt");
	pcb_block_a: assert property (cStart ##0 pcbHit |=> selectN_ff == 10'h3ff)
		else $error("select on register block access");
	idle_none_a: assert property (cStart ##0 (cycleStatus == 3'h7 && !refreshCycle)
		|=> selectN_ff == 10'h3ff) else $error("select on idle status");
	start_cause_a: assert property (selectN_ff != 10'h3ff && $past(selectN_ff) == 10'h3ff
		|-> $past(clkEn && cycleStart && !cycleEnd)) else $error("select without start");
	sel_hold_a: assert property (!(clkEn && (cycleStart || cycleEnd)) |=> $stable(selectN_ff))
		else $error("select moved mid cycle");
	reset_state_a: assert property (disable iff (1'b0) clkEn && reset |=>
		selectN_ff == 10'h3ff && !waitReq_ff && !busyClaim_ff) else $error("bad reset state");
	idle_wait_a: assert property (selectN_ff == 10'h3ff |-> !waitReq_ff)
		else $error("wait without select");
	claim_flag_a: assert property (selectN_ff != 10'h3ff |-> busyClaim_ff)
		else $error("select without claim");
	bad_index_a: assert property (clkEn && regRead && regIndex > 5'd20 |=> regRdata_ff == 16'h0)
		else $error("unmapped read not zero");
endmodule
bind pcsu_chip_select pcsu_checker u_chk(.mclk, .reset, .clkEn, .cycleStart, .cycleEnd,
	.refreshCycle, .pcbHit, .busReady, .regWrite, .regRead, .waitReq_ff, .busyClaim_ff,
	.busAddr, .cycleStatus, .regIndex, .regWdata, .regRdata_ff, .selectN_ff);

/* testbench/pcsu_mem_model.sv */
// Far-side memory model that stretches selected cycles by holding ready low
`timescale 1ns/10ps
module pcsu_mem_model
(
	input  wire       mclk,     // Bus clock
	input  wire [9:0] selectN,  // Active-low selects from the decoder
	input  wire [3:0] slow,     // Extra cycles before ready, zero answers at once
	output wire       busReady  // Ready pin, pulled up while nothing is selected
);
	reg [3:0] cnt;  // Cycles spent selected
	initial cnt = 4'h0;
	// Count while selected, saturate at the slow figure
	always @(posedge mclk)
		cnt <= (&selectN) ? 4'h0 : ((cnt < slow) ? cnt + 4'h1 : cnt);
	// Ready low until the slow count runs out; pull-up when released
	assign busReady = (&selectN) | (cnt == slow);
endmodule

/* testbench/tb_programmable_chip_select_unit.sv */
// Self-checking bench for the chip-select decoder
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_programmable_chip_select_unit;
	reg mclk, reset, clkEn, cycleStart, cycleEnd, refreshCycle, pcbHit, regWrite, regRead;
	reg [19:0] busAddr;
	reg [2:0] cycleStatus;
	reg [4:0] regIndex;
	reg [15:0] regWdata;
	reg [3:0] slow;  // Partner stretch setting
	wire busReady, waitReq_ff, busyClaim_ff;
	wire [15:0] regRdata_ff;
	wire [9:0] selectN_ff;
	integer n_fail = 0, comparisons = 0, cyc = 0;
	pcsu_chip_select u_dut(.mclk, .reset, .clkEn, .cycleStart, .cycleEnd, .busAddr, .cycleStatus,
		.refreshCycle, .pcbHit, .busReady, .regWrite, .regRead, .regIndex, .regWdata,
		.regRdata_ff, .selectN_ff, .waitReq_ff, .busyClaim_ff);
	pcsu_mem_model u_mem(.mclk, .selectN(selectN_ff), .slow, .busReady);
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			summarize;
		end
	end
	task summarize;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Register write and checked read
	task wr(input [4:0] i, input [15:0] d);
		regIndex = i; regWdata = d; regWrite = 1;
		@(posedge mclk); #1 regWrite = 0;
	endtask
	task rd(input [4:0] i, input [15:0] e);
		regIndex = i; regRead = 1;
		@(posedge mclk); #1 regRead = 0;
		`CHK(regRdata_ff, e)
	endtask
	// One bus cycle: select, count waits, end; w of -1 skips the wait check, -2 needs more than two waits
	task bc(input [19:0] a, input [2:0] s, input [1:0] f, input [9:0] e, input integer w);
		integer n;
		busAddr = a; cycleStatus = s; {pcbHit, refreshCycle} = f; cycleStart = 1;
		@(posedge mclk); #1 cycleStart = 0;
		`CHK(selectN_ff, e)
		n = 0;
		while (waitReq_ff === 1'b1 && n < 40)
		begin
			@(posedge mclk); #1 n++;
		end
		if (w >= 0) `CHK(n, w)
		if (w == -2) `CHK(n > 2, 1'b1)
		cycleEnd = 1; cycleStatus = 3'h7;
		@(posedge mclk); #1 cycleEnd = 0;
		`CHK(selectN_ff, 10'h3ff)
	endtask
	task t_reset;
		rd(5'd18, 16'hffcf);
		rd(5'd19, 16'hffed);
		rd(5'd1, 16'hffc5);
		bc(20'hffc00, 3'h0, 2'b00, 10'h1ff, 15);
		wr(5'd2, 16'hffff);
		rd(5'd2, 16'hffcf);
		rd(5'd21, 16'h0);
		$display("reset and registers done");
	endtask
	task t_window;
		wr(5'd0, 16'h1000);
		wr(5'd1, 16'h1124);
		bc(20'h0fc00, 3'h0, 2'b00, 10'h3ff, 0);
		bc(20'h10000, 3'h0, 2'b00, 10'h3fe, 0);
		bc(20'h10fff, 3'h2, 2'b00, 10'h3fe, 0);
		bc(20'h10c00, 3'h1, 2'b00, 10'h3fe, 0);
		bc(20'h11000, 3'h0, 2'b00, 10'h3ff, 0);
		bc(20'h10000, 3'h3, 2'b00, 10'h3ff, 0);
		bc(20'h10000, 3'h7, 2'b01, 10'h3fe, 0);
		bc(20'h10000, 3'h0, 2'b10, 10'h3ff, 0);
		bc(20'h10000, 3'h5, 2'b00, 10'h3ff, 0);
		bc(20'h10000, 3'h6, 2'b00, 10'h3ff, 0);
		$display("memory window done");
	endtask
	task t_io;
		wr(5'd2, 16'h0402);
		wr(5'd3, 16'h0029);
		bc(20'h00400, 3'h3, 2'b00, 10'h3fd, 2);
		bc(20'h0ffc0, 3'h4, 2'b00, 10'h3fd, 2);
		bc(20'h003c0, 3'h3, 2'b00, 10'h3ff, 0);
		bc(20'h00400, 3'h0, 2'b00, 10'h3ff, 0);
		// Six minimum waits cover the ready synchroniser's latency
		wr(5'd2, 16'h0406);
		slow = 4'h8;
		bc(20'h00400, 3'h4, 2'b00, 10'h3fd, -2);
		slow = 4'h0;
		// Frozen clock enable: start not taken, no select
		clkEn = 0;
		bc(20'h00400, 3'h3, 2'b00, 10'h3ff, 0);
		clkEn = 1;
		$display("io window and ready done");
	endtask
	initial
	begin
		{cycleStart, cycleEnd, refreshCycle, pcbHit, regWrite, regRead} = 0;
		busAddr = 0; cycleStatus = 3'h7; regIndex = 0; regWdata = 0; slow = 0;
		reset = 1; clkEn = 1;
		repeat (12) @(posedge mclk);
		#1 reset = 0;
		t_reset;
		t_window;
		t_io;
		summarize;
	end
endmodule
